// >>> verilog/charger_config_regs_1_to_4.sv
// Purpose: configuration registers 1 to 4 of a single-cell charger, plus reset-pin battery disconnect
// Assumes: the serial slave engine delivers decoded register writes and reads on mclk
// Notes: alert pin is asynchronous and synchronised before use
//
// How it works
// - bits 7:6 of reg 1 pick alert-low debounce 8, 12, 16 or 20 s.
// - bit 5 of reg 1 picks battery switch off time 2 s or 4 s.
// - bit 4 of reg 1 turns the input-to-system regulator switch off.
// - bit 3 of reg 1 blocks charging when set; default blocks.
// - bits 2:0 of reg 1 set undervoltage level, default code 100.
// - reg 2 bit 7 restores all defaults; watchdog restores all but that bit.
// - writing reg 2 bit 6 restarts the serial watchdog timer.
// - bits 5:0 of reg 2 hold fast-charge current code, default 001111.
// - bits 7:4 of reg 3 hold discharge limit, default 1001.
// - bits 7:2 of reg 4 hold regulation voltage code, default 101000.
// - bit 1 of reg 4 picks precharge handover 2.8 V or 3.0 V.
// - bit 0 of reg 4 picks recharge margin 100 mV or 200 mV.
// - reg 1 resets to ac, reg 2 to 0f.
// - reg 3 resets to 91, reg 4 to a3.
// - after debounce the battery switch stays off, then turns back on.
// - an external serial master writes and reads these registers.
`timescale 1ns/100ps
module charger_config_regs_1_to_4
    import charger_cfg_pkg::*;
#(
    parameter longint debounce_cycles_0 = debounce_s0 * clk_hz,
    parameter longint debounce_cycles_1 = debounce_s1 * clk_hz,
    parameter longint debounce_cycles_2 = debounce_s2 * clk_hz,
    parameter longint debounce_cycles_3 = debounce_s3 * clk_hz,
    parameter longint disconnect_cycles_0 = disconnect_s0 * clk_hz,
    parameter longint disconnect_cycles_1 = disconnect_s1 * clk_hz
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register access from the serial slave engine
    input wire reg_write_type bus_wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // watchdog
    input wire logic watchdog_expiry,
    output logic watchdog_restart,
    // alert pin, active low
    input wire logic alert_b,
    // configuration outputs
    output charger_cfg_type cfg,
    output logic battery_switch_on
);

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    logic [7:0] cfg1_reg;
    logic [7:0] cfg2_reg;
    logic [7:0] cfg3_reg;
    logic [7:0] cfg4_reg;
    logic reg_reset_pending_reg;
    logic wr1;
    logic wr2;
    logic wr3;
    logic wr4;

    // unmapped offsets give no strobe, so such writes are dropped
    assign wr1 = bus_wr.write && (bus_wr.addr == cfg1_offset);
    assign wr2 = bus_wr.write && (bus_wr.addr == cfg2_offset);
    assign wr3 = bus_wr.write && (bus_wr.addr == cfg3_offset);
    assign wr4 = bus_wr.write && (bus_wr.addr == cfg4_offset);

    // ---------------------------------------------------------------
    // register reset request
    // ---------------------------------------------------------------
    // applied on the cycle after the write, so the command byte is not kept
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            reg_reset_pending_reg <= 1'b0;
        else
            reg_reset_pending_reg <= wr2 && bus_wr.wdata[reg_reset_bit];
    end

    // ---------------------------------------------------------------
    // register 1: reset pin, input path, charge and undervoltage
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg1_reg <= cfg1_reset;
        else if (reg_reset_pending_reg)
            cfg1_reg <= cfg1_reset;
        else if (watchdog_expiry)
            cfg1_reg <= cfg1_reset;
        else if (wr1)
            cfg1_reg <= bus_wr.wdata;
    end

    // ---------------------------------------------------------------
    // register 2: reset and restart commands, fast-charge current
    // ---------------------------------------------------------------
    // bit 7 survives expiry; bit 6 is a strobe and is never stored
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg2_reg <= cfg2_reset;
        else if (reg_reset_pending_reg)
            cfg2_reg <= cfg2_reset;
        else if (watchdog_expiry)
            cfg2_reg <= {cfg2_reg[reg_reset_bit], cfg2_reset[wdog_restart_bit:0]};
        else if (wr2)
            cfg2_reg <= {bus_wr.wdata[reg_reset_bit], 1'b0, bus_wr.wdata[fast_current_msb:0]};
    end

    // ---------------------------------------------------------------
    // register 3: discharge limit and termination current
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg3_reg <= cfg3_reset;
        else if (reg_reset_pending_reg)
            cfg3_reg <= cfg3_reset;
        else if (watchdog_expiry)
            cfg3_reg <= cfg3_reset;
        else if (wr3)
            cfg3_reg <= bus_wr.wdata;
    end

    // ---------------------------------------------------------------
    // register 4: regulation voltage and thresholds
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg4_reg <= cfg4_reset;
        else if (reg_reset_pending_reg)
            cfg4_reg <= cfg4_reset;
        else if (watchdog_expiry)
            cfg4_reg <= cfg4_reset;
        else if (wr4)
            cfg4_reg <= bus_wr.wdata;
    end

    // ---------------------------------------------------------------
    // watchdog restart pulse
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            watchdog_restart <= 1'b0;
        else
            watchdog_restart <= wr2 && bus_wr.wdata[wdog_restart_bit];
    end

    // ---------------------------------------------------------------
    // read back
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data <= 8'h00;
        else
        begin
            // unmapped offsets read as zero
            unique case (rd_addr)
                cfg1_offset: rd_data <= cfg1_reg;
                cfg2_offset: rd_data <= cfg2_reg;
                cfg3_offset: rd_data <= cfg3_reg;
                cfg4_offset: rd_data <= cfg4_reg;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // configuration outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg <= '0;
        else
        begin
            // field copies run one cycle behind the registers
            cfg.debounce_sel <= cfg1_reg[debounce_msb:debounce_lsb];
            cfg.disconnect_long <= cfg1_reg[disconnect_dur_bit];
            cfg.input_path_off <= cfg1_reg[input_path_off_bit];
            cfg.charge_inhibit <= cfg1_reg[charge_inhibit_bit];
            cfg.battery_undervoltage_level <= cfg1_reg[uvlo_msb:0];
            cfg.fast_charge_current <= cfg2_reg[fast_current_msb:0];
            cfg.discharge_current_limit <= cfg3_reg[discharge_msb:discharge_lsb];
            cfg.termination_current <= cfg3_reg[termination_msb:0];
            cfg.battery_regulation_voltage <= cfg4_reg[regulation_msb:regulation_lsb];
            cfg.precharge_handover_level <= cfg4_reg[precharge_bit];
            cfg.recharge_margin <= cfg4_reg[recharge_bit];
        end
    end

    // ---------------------------------------------------------------
    // alert pin synchroniser
    // ---------------------------------------------------------------
    logic alert_meta_reg;
    logic alert_sync_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alert_meta_reg <= 1'b1;
            alert_sync_reg <= 1'b1;
        end
        else
        begin
            alert_meta_reg <= alert_b;
            alert_sync_reg <= alert_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // battery disconnect sequencer
    // ---------------------------------------------------------------
    switch_state_type state_reg;
    logic [count_width-1:0] count_reg;
    logic [count_width-1:0] debounce_limit;
    logic [count_width-1:0] off_limit;

    always_comb
    begin
        unique case (cfg1_reg[debounce_msb:debounce_lsb])
            2'b00: debounce_limit = count_width'(debounce_cycles_0 - 1);
            2'b01: debounce_limit = count_width'(debounce_cycles_1 - 1);
            2'b10: debounce_limit = count_width'(debounce_cycles_2 - 1);
            default: debounce_limit = count_width'(debounce_cycles_3 - 1);
        endcase
    end

    // both limits follow the register live, so a write during a count moves its end point
    always_comb
    begin
        if (cfg1_reg[disconnect_dur_bit])
            off_limit = count_width'(disconnect_cycles_1 - 1);
        else
            off_limit = count_width'(disconnect_cycles_0 - 1);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= sw_on;
            count_reg <= '0;
            battery_switch_on <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                sw_on:
                begin
                    count_reg <= '0;
                    if (!alert_sync_reg)
                        state_reg <= sw_debounce;
                end
                sw_debounce:
                begin
                    // a release before the limit aborts; a fresh low counts from zero
                    if (alert_sync_reg)
                    begin
                        state_reg <= sw_on;
                        count_reg <= '0;
                    end
                    else if (count_reg >= debounce_limit)
                    begin
                        state_reg <= sw_off;
                        count_reg <= '0;
                        battery_switch_on <= 1'b0;
                    end
                    else
                        count_reg <= count_reg + 1'b1;
                end
                sw_off:
                begin
                    // alert level is ignored while off
                    if (count_reg >= off_limit)
                    begin
                        state_reg <= sw_on;
                        count_reg <= '0;
                        battery_switch_on <= 1'b1;
                    end
                    else
                        count_reg <= count_reg + 1'b1;
                end
                default:
                begin
                    state_reg <= sw_on;
                    count_reg <= '0;
                    battery_switch_on <= 1'b1;
                end
            endcase
        end
    end

endmodule : charger_config_regs_1_to_4

// >>> shared/charger_cfg_pkg.sv
// Purpose: constants and types for the charger configuration bank
// Assumes: 8-bit registers at byte offsets 01h to 04h
// Notes: times in seconds, cycle counts derived at 100 MHz
package charger_cfg_pkg;
    // ---------------------------------------------------------------
    // register offsets and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] cfg1_offset = 8'h01;
    localparam logic [7:0] cfg2_offset = 8'h02;
    localparam logic [7:0] cfg3_offset = 8'h03;
    localparam logic [7:0] cfg4_offset = 8'h04;
    localparam logic [7:0] cfg1_reset = 8'hac;
    localparam logic [7:0] cfg2_reset = 8'h0f;
    localparam logic [7:0] cfg3_reset = 8'h91;
    localparam logic [7:0] cfg4_reset = 8'ha3;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int debounce_msb = 7;
    localparam int debounce_lsb = 6;
    localparam int disconnect_dur_bit = 5;
    localparam int input_path_off_bit = 4;
    localparam int charge_inhibit_bit = 3;
    localparam int uvlo_msb = 2;
    localparam int reg_reset_bit = 7;
    localparam int wdog_restart_bit = 6;
    localparam int fast_current_msb = 5;
    localparam int discharge_msb = 7;
    localparam int discharge_lsb = 4;
    localparam int termination_msb = 3;
    localparam int regulation_msb = 7;
    localparam int regulation_lsb = 2;
    localparam int precharge_bit = 1;
    localparam int recharge_bit = 0;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam longint clk_hz = 100000000;
    localparam longint debounce_s0 = 8;
    localparam longint debounce_s1 = 12;
    localparam longint debounce_s2 = 16;
    localparam longint debounce_s3 = 20;
    localparam longint disconnect_s0 = 2;
    localparam longint disconnect_s1 = 4;
    localparam int count_width = 32;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        sw_on = 2'b00,
        sw_debounce = 2'b01,
        sw_off = 2'b11
    } switch_state_type;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_write_type;

    typedef struct packed {
        logic [1:0] debounce_sel;
        logic disconnect_long;
        logic input_path_off;
        logic charge_inhibit;
        logic [2:0] battery_undervoltage_level;
        logic [5:0] fast_charge_current;
        logic [3:0] discharge_current_limit;
        logic [3:0] termination_current;
        logic [5:0] battery_regulation_voltage;
        logic precharge_handover_level;
        logic recharge_margin;
    } charger_cfg_type;
endpackage : charger_cfg_pkg

// >>> tb/charger_cfg_properties.sv
// Purpose: port checks for the charger configuration bank
// Assumes: shortened debounce and off counts handed on by bind
// Notes: bound into every instance of the bank
`timescale 1ns/100ps
module charger_cfg_properties
    import charger_cfg_pkg::*;
#(
    parameter longint debounce_cycles_0 = 20,
    parameter longint disconnect_cycles_0 = 10,
    parameter longint disconnect_cycles_1 = 20
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register access
    input wire reg_write_type bus_wr,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    // watchdog and pin
    input wire logic watchdog_expiry,
    input wire logic watchdog_restart,
    input wire logic alert_b,
    // outputs
    input wire charger_cfg_type cfg,
    input wire logic battery_switch_on
);
    logic [29:0] dflt;
    logic [31:0] low_reg;
    logic [31:0] off_reg;
    assign dflt = {cfg1_reset, cfg2_reset[5:0], cfg3_reset, cfg4_reset};
    // ---------------------------------------------------------------
    // run lengths of alert low and switch off
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            low_reg <= '0;
        else
            low_reg <= alert_b ? '0 : low_reg + 32'h1;
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            off_reg <= '0;
        else
            off_reg <= battery_switch_on ? '0 : off_reg + 32'h1;
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence s_reset_cmd;
        bus_wr.write && bus_wr.addr == 8'h02 && bus_wr.wdata[7] && !watchdog_expiry;
    endsequence
    property p_reg_reset;
        s_reset_cmd |-> ##[2:3] cfg == dflt;
    endproperty
    property p_wdog_exp;
        watchdog_expiry |-> ##2 cfg == dflt;
    endproperty
    property p_wdog_pulse;
        bus_wr.write && bus_wr.addr == 8'h02 && bus_wr.wdata[6] && !watchdog_expiry |=> watchdog_restart;
    endproperty
    property p_wdog_cause;
        watchdog_restart |-> $past(bus_wr.write) && $past(bus_wr.wdata[6]);
    endproperty
    property p_rd_unmapped;
        !(rd_addr inside {[8'h01:8'h04]}) |=> rd_data == 8'h00;
    endproperty
    property p_rd_reg1;
        rd_addr == 8'h01 |=> rd_data == cfg[29:22];
    endproperty
    property p_rd_reg2;
        rd_addr == 8'h02 |=> rd_data[6:0] == {1'b0, cfg.fast_charge_current};
    endproperty
    property p_deb_min;
        $fell(battery_switch_on) |-> low_reg >= debounce_cycles_0;
    endproperty
    property p_off_min;
        $rose(battery_switch_on) |-> off_reg >= disconnect_cycles_0;
    endproperty
    property p_off_max;
        !battery_switch_on |-> off_reg <= disconnect_cycles_1 + 4;
    endproperty
    a_reg_reset: assert property (p_reg_reset)
        else $error("register reset left a field changed");
    a_wdog_exp: assert property (p_wdog_exp)
        else $error("watchdog expiry left a field changed");
    a_wdog_pulse: assert property (p_wdog_pulse)
        else $error("restart pulse missing");
    a_wdog_cause: assert property (p_wdog_cause)
        else $error("restart pulse without command");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
    a_rd_reg1: assert property (p_rd_reg1)
        else $error("reg 1 read and fields differ");
    a_rd_reg2: assert property (p_rd_reg2)
        else $error("reg 2 read and fields differ");
    a_deb_min: assert property (p_deb_min)
        else $error("switch off before debounce");
    a_off_min: assert property (p_off_min)
        else $error("switch back on too early");
    a_off_max: assert property (p_off_max)
        else $error("switch stays off too long");
endmodule : charger_cfg_properties

bind charger_config_regs_1_to_4 charger_cfg_properties #(.debounce_cycles_0(debounce_cycles_0),
    .disconnect_cycles_0(disconnect_cycles_0), .disconnect_cycles_1(disconnect_cycles_1)) props (
    .mclk(mclk), .rst_b(rst_b), .bus_wr(bus_wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .watchdog_expiry(watchdog_expiry), .watchdog_restart(watchdog_restart), .alert_b(alert_b),
    .cfg(cfg), .battery_switch_on(battery_switch_on));

// >>> tb/cfg_host_model.sv
// Purpose: serial host stand-in issuing decoded register accesses
// Assumes: one byte per access, changes just after the edge
// Notes: idle write fields show the inverse of the last byte
`timescale 1ns/100ps
module cfg_host_model
    import charger_cfg_pkg::*;
(
    // clock
    input wire logic mclk,
    // register access
    output reg_write_type bus_wr,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial
    begin
        bus_wr = '0;
        rd_addr = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 bus_wr = {1'b1, a, d};
        @(posedge mclk);
        #1 bus_wr = {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1 rd_addr = a;
        @(posedge mclk);
        #1 d = rd_data;
    endtask : rd
endmodule : cfg_host_model

// >>> tb/charger_config_regs_1_to_4_tb_top.sv
// Purpose: self-checking bench for the charger configuration bank
// Assumes: debounce 20/30/40/50 and off 10/20 cycles
// Notes: host model drives the register side
`timescale 1ns/100ps
module charger_config_regs_1_to_4_tb_top
    import charger_cfg_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic watchdog_expiry = 1'b0;
    logic alert_b = 1'b1;
    reg_write_type bus_wr;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic watchdog_restart;
    charger_cfg_type cfg;
    logic battery_switch_on;
    logic [7:0] dv [1:4] = '{cfg1_reset, cfg2_reset, cfg3_reset, cfg4_reset};
    int n_mismatch = 0;
    int checks = 0;
    localparam longint deb_cycles = 20;
    localparam longint off_cycles = 10;
    always #5 mclk = ~mclk;
    cfg_host_model host (.mclk(mclk), .bus_wr(bus_wr), .rd_addr(rd_addr), .rd_data(rd_data));
    charger_config_regs_1_to_4 #(.debounce_cycles_0(deb_cycles), .debounce_cycles_1(deb_cycles + 10),
        .debounce_cycles_2(deb_cycles + 20), .debounce_cycles_3(deb_cycles + 30),
        .disconnect_cycles_0(off_cycles), .disconnect_cycles_1(2 * off_cycles)) dut (
        .mclk(mclk), .rst_b(rst_b), .bus_wr(bus_wr), .rd_addr(rd_addr), .rd_data(rd_data),
        .watchdog_expiry(watchdog_expiry), .watchdog_restart(watchdog_restart), .alert_b(alert_b),
        .cfg(cfg), .battery_switch_on(battery_switch_on));
    task automatic summarize;
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        cmp(d, e);
    endtask : rdchk
    task automatic t_fields;
        host.wr(8'h01, 8'h53);
        host.wr(8'h02, 8'h38);
        host.wr(8'h03, 8'hf0);
        host.wr(8'h04, 8'hfc);
        host.wr(8'h07, 8'h00);
        rdchk(8'h01, 8'h53);
        rdchk(8'h02, 8'h38);
        rdchk(8'h03, 8'hf0);
        rdchk(8'h04, 8'hfc);
        cmp({cfg.input_path_off, cfg.charge_inhibit, 6'h00}, 8'h80);
        cmp({2'b00, cfg.battery_regulation_voltage}, 8'h3f);
        cmp({cfg.precharge_handover_level, cfg.recharge_margin, 6'h00}, 8'h00);
        cmp({cfg.debounce_sel, cfg.disconnect_long, cfg.battery_undervoltage_level, 2'b00}, 8'h4c);
        cmp({2'b00, cfg.fast_charge_current}, 8'h38);
        cmp({cfg.discharge_current_limit, cfg.termination_current}, 8'hf0);
    endtask : t_fields
    task automatic t_wdog;
        host.wr(8'h02, 8'h4a);
        cmp({7'h00, watchdog_restart}, 8'h01);
        @(posedge mclk);
        #1 cmp({7'h00, watchdog_restart}, 8'h00);
        rdchk(8'h02, 8'h0a);
        host.wr(8'h02, 8'h80);
        for (int i = 1; i < 5; i++)
            rdchk(8'(i), dv[i]);
        for (int i = 1; i < 5; i++)
            host.wr(8'(i), 8'h55);
        @(posedge mclk);
        #1 watchdog_expiry = 1'b1;
        @(posedge mclk);
        #1 watchdog_expiry = 1'b0;
        for (int i = 1; i < 5; i++)
            rdchk(8'(i), dv[i]);
    endtask : t_wdog
    task automatic t_alert(input logic [1:0] sel, input logic dur);
        int n;
        host.wr(8'h01, {sel, dur, 5'h0c});
        alert_b = 1'b0;
        n = 0;
        while (battery_switch_on === 1'b1 && n < 90)
        begin
            @(posedge mclk);
            #1 n++;
        end
        alert_b = 1'b1;
        cmp(8'(n >= deb_cycles + 10 * sel && n <= deb_cycles + 5 + 10 * sel), 8'h01);
        n = 0;
        while (battery_switch_on === 1'b0 && n < 40)
        begin
            @(posedge mclk);
            #1 n++;
        end
        cmp(8'(n >= off_cycles * (1 + dur) && n <= off_cycles * (1 + dur) + 3), 8'h01);
    endtask : t_alert
    task automatic t_abort;
        logic off_seen = 1'b0;
        alert_b = 1'b0;
        repeat (15) @(posedge mclk);
        #1 alert_b = 1'b1;
        repeat (60)
        begin
            @(posedge mclk);
            #1 off_seen = off_seen | !battery_switch_on;
        end
        cmp({7'h00, off_seen}, 8'h00);
    endtask : t_abort
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 rst_b = 1'b1;
        for (int i = 1; i < 5; i++)
            rdchk(8'(i), dv[i]);
        rdchk(8'h05, 8'h00);
        t_fields();
        t_wdog();
        for (int s = 0; s < 4; s++)
            t_alert(2'(s), s[0]);
        t_abort();
        summarize();
    end
    initial
    begin
        #50000;
        n_mismatch++;
        summarize();
    end
endmodule : charger_config_regs_1_to_4_tb_top
